/* File: design/cal_controller_end.sv */
// Purpose: controller end issuing select then command after the latency
// Assumes: user issues one request at a time and waits for ready
// Notes:   addr[15:13] selects mode register for mode writes
`timescale 1ns/1ps
`default_nettype none
module cal_controller_end (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // link
    cal_link_if.controller     link,
    // user side
    input  wire logic          req_valid,
    input  wire cal_pkg::cmd_type req_cmd,
    input  wire logic [15:0]   req_addr,
    input  wire logic          gear_down,
    input  wire logic          fast_bin,
    output logic               req_ready,
    output logic               refused_q
);
    import cal_pkg::*;

    typedef enum {st_idle, st_latency, st_wait, st_self, st_down} state_type;
    state_type   state_q;
    logic [3:0]  lat_q, cnt_q, lat_new, lat_req;
    logic [15:0] wait_q;
    logic        selfref_q;
    cmd_type     cmd_hold_q;
    logic [15:0] addr_hold_q;
    logic        allowed;
    logic [2:0]  code_new;
    logic [15:0] req_addr_adj;
    logic [3:0]  lat_hold;

    assign lat_req = decode_cal(req_addr[cal_field_lsb +: 3]);
    // programmed code below the floor, or odd in gear-down with fast_bin set, is raised
    always_comb begin
        lat_new = lat_req;
        if (lat_new != 4'h0 && lat_new < cal_min_clocks) lat_new = cal_min_clocks;
        if (gear_down && fast_bin && lat_new[0]) lat_new = lat_new + 4'h1;
    end
    // the raised latency is the code sent, so both ends count the same clocks
    always_comb begin
        unique case (lat_new)
            4'h4:    code_new = 3'h2;
            4'h6:    code_new = 3'h4;
            4'h8:    code_new = 3'h5;
            default: code_new = req_addr[cal_field_lsb +: 3];
        endcase
        req_addr_adj = req_addr;
        if (req_cmd == cmd_mode_write && req_addr[15:13] == 3'h4) begin
            req_addr_adj[cal_field_lsb +: 3] = code_new;
        end
    end
    // taken from the held word: the user may change req_addr while we wait
    assign lat_hold = decode_cal(addr_hold_q[cal_field_lsb +: 3]);
    // only mode writes, calibration and exit while in self refresh
    assign allowed = !selfref_q || req_cmd == cmd_mode_write || req_cmd == cmd_calibrate
                     || req_cmd == cmd_exit;
    assign req_ready = (state_q == st_idle) || (state_q == st_self) || (state_q == st_down);

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q     <= st_idle;
            cnt_q       <= 4'h0;
            wait_q      <= 16'h0000;
            lat_q       <= 4'h0;
            selfref_q   <= 1'b0;
            refused_q   <= 1'b0;
            cmd_hold_q  <= cmd_nop;
            addr_hold_q <= 16'h0000;
        end else begin
            refused_q <= 1'b0;
            unique case (state_q)
                st_idle, st_self, st_down: begin
                    if (req_valid && !allowed) begin
                        refused_q <= 1'b1;
                    end else if (req_valid) begin
                        cmd_hold_q  <= req_cmd;
                        addr_hold_q <= req_addr_adj;
                        cnt_q       <= lat_q;
                        state_q     <= st_latency;
                    end
                end
                st_latency: begin
                    if (cnt_q <= 4'h1) begin
                        state_q <= st_wait;
                        wait_q  <= 16'h0001;
                        if (cmd_hold_q == cmd_mode_write && addr_hold_q[15:13] == 3'h4) begin
                            lat_q <= lat_hold;
                            wait_q <= {8'h00, mode_update_cycles} + {12'h000, lat_hold};
                        end else if (cmd_hold_q == cmd_mode_write) begin
                            wait_q <= {8'h00, mode_update_cycles} + {12'h000, lat_q};
                        end else if (cmd_hold_q == cmd_selfrefresh_enter) begin
                            selfref_q <= 1'b1;
                            wait_q <= {8'h00, clock_hold_after_selfrefresh_entry};
                        end else if (cmd_hold_q == cmd_powerdown_enter) begin
                            wait_q <= {8'h00, min_powerdown_time};
                        end else if (cmd_hold_q == cmd_refresh) begin
                            wait_q <= {8'h00, refresh_to_powerdown_wait};
                        end else if (cmd_hold_q == cmd_exit) begin
                            wait_q <= selfref_q ? fast_exit_cycles
                                      : {8'h00, powerdown_exit_wait};
                            selfref_q <= 1'b0;
                        end
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                st_wait: begin
                    if (wait_q <= 16'h0001) begin
                        state_q <= (cmd_hold_q == cmd_selfrefresh_enter) ? st_self :
                                   (cmd_hold_q == cmd_powerdown_enter) ? st_down : st_idle;
                    end else begin
                        wait_q <= wait_q - 16'h0001;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    // select leads command by the latency; both at once when latency is off
    always_comb begin
        link.select_n = !((state_q != st_latency && req_valid && allowed && req_ready)
                          ? (lat_q == 4'h0) : 1'b0);
        if (req_valid && allowed && req_ready && lat_q != 4'h0) link.select_n = 1'b0;
        if (state_q == st_latency && cnt_q == 4'h1) link.select_n = 1'b1;
        link.cmd  = (state_q == st_latency && cnt_q <= 4'h1) ? cmd_hold_q
                    : (lat_q == 4'h0 && req_valid && allowed && req_ready) ? req_cmd : cmd_nop;
        link.addr = (state_q == st_latency && cnt_q <= 4'h1) ? addr_hold_q
                    : (lat_q == 4'h0 && req_valid && allowed && req_ready) ? req_addr_adj
                    : 16'h0000;
    end
endmodule : cal_controller_end
`default_nettype wire

/* File: design/cal_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cal_link_if;
    logic                 select_n;
    cal_pkg::cmd_type     cmd;
    logic [15:0]          addr;
    modport controller (output select_n, output cmd, output addr);
    modport memory     (input select_n, input cmd, input addr);
endinterface : cal_link_if
`default_nettype wire

/* File: design/cal_memory_end.sv */
// Purpose: memory end capturing commands after the select-to-command latency
// Assumes: controller keeps its own timing obligations
// Notes:   reserved codes decode as disabled
`timescale 1ns/1ps
`default_nettype none
module cal_memory_end (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // link
    cal_link_if.memory         link,
    // user side
    output logic               receivers_on,
    output logic               cmd_valid_q,
    output cal_pkg::cmd_type   cmd_q,
    output logic [15:0]        addr_q,
    output logic [3:0]         select_to_command_cycles
);
    import cal_pkg::*;

    logic [2:0]  code_q;
    logic [3:0]  lat;
    logic [8:0]  sel_pipe_q;
    logic        pending;

    assign lat = decode_cal(code_q);
    assign select_to_command_cycles = lat;

    ////////////////////////////////////////////////////////////////
    // select delay line, one bit per clock of latency
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sel_pipe_q <= 9'h000;
        end else begin
            sel_pipe_q <= {sel_pipe_q[7:0], ~link.select_n};
        end
    end

    // any select still inside its latency window keeps receivers on
    always_comb begin
        pending = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(lat)) begin
                pending = pending | sel_pipe_q[i];
            end
        end
    end
    // overlap of windows covers back-to-back commands
    assign receivers_on = (lat == 4'h0) ? 1'b1 : (pending | ~link.select_n);

    ////////////////////////////////////////////////////////////////
    // capture: latency off means capture with select itself
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmd_valid_q <= 1'b0;
            cmd_q       <= cmd_nop;
            addr_q      <= 16'h0000;
        end else if ((lat == 4'h0) ? ~link.select_n : sel_pipe_q[lat - 4'h1]) begin
            cmd_valid_q <= 1'b1;
            cmd_q       <= link.cmd;
            addr_q      <= link.addr;
        end else begin
            cmd_valid_q <= 1'b0;
        end
    end

    // mode register four write updates latency field
    always_ff @(posedge clk) begin
        if (!resetn) begin
            code_q <= cal_reset_code;
        end else if (cmd_valid_q && cmd_q == cmd_mode_write && addr_q[15:13] == 3'h4) begin
            code_q <= addr_q[cal_field_lsb +: 3];
        end
    end
endmodule : cal_memory_end
`default_nettype wire

/* File: design/cal_pkg.sv */
// Purpose: shared constants and types for the select-to-command latency link
// Assumes: one 50 MHz clock shared by controller and memory end
// Notes:   memory end models only latency capture and receiver gating
//
// What this block does
// - command phase follows select by programmed latency
// - receivers powered during latency, off after capture
// - receivers stay on through back-to-back commands
// - code 000 off, then 3,4,5,6,8 clocks
// - controller latency at least max(3 clocks, 3.748ns)
// - gear-down latency rounded up to even when fast_bin set
// - gear-down only at 2666 rate and above; the controller takes gear_down at any rate, with no rate check
// - next command waits mode-update plus latency
// - mode writes spaced mode-update plus latency
// - waits computed from newly written latency
// - self refresh allows only mode write, calibration, exit
// - self refresh clock hold 8, fast exit wait
// - power-down min 6, exit 5, pass delay 4
// - power-down may follow refresh after 1 clock
package cal_pkg;
    localparam int unsigned clk_period_ps = 20000;
    localparam int unsigned cal_min_ps    = 3748;
    localparam int unsigned cal_min_time_cycles =
        (cal_min_ps + clk_period_ps - 1) / clk_period_ps;
    localparam logic [3:0] cal_min_clocks = 4'h3;
    localparam int unsigned cal_field_lsb = 6;
    localparam logic [2:0] cal_reset_code = 3'h0;
    localparam logic [7:0] mode_update_cycles = 8'h18;
    localparam logic [7:0] clock_hold_after_selfrefresh_entry = 8'h08;
    localparam logic [7:0] clock_stable_before_selfrefresh_exit = 8'h08;
    localparam logic [7:0] min_powerdown_time = 8'h06;
    localparam logic [7:0] powerdown_exit_wait = 8'h05;
    localparam logic [7:0] command_pass_powerdown_delay = 8'h04;
    localparam logic [7:0] refresh_to_powerdown_wait = 8'h01;
    localparam logic [15:0] refresh4_ns = 16'h015e;
    localparam logic [15:0] fast_exit_extra_ns = 16'h000a;
    localparam logic [15:0] clk_period_ns = 16'h0014;
    localparam logic [15:0] fast_exit_cycles =
        (refresh4_ns + fast_exit_extra_ns + clk_period_ns - 16'h0001) / clk_period_ns;

    typedef enum logic [2:0] {
        cmd_nop, cmd_mode_write, cmd_refresh, cmd_calibrate,
        cmd_selfrefresh_enter, cmd_powerdown_enter, cmd_exit, cmd_other
    } cmd_type;

    function automatic logic [3:0] decode_cal(input logic [2:0] code);
        unique case (code)
            3'h1:    decode_cal = 4'h3;
            3'h2:    decode_cal = 4'h4;
            3'h3:    decode_cal = 4'h5;
            3'h4:    decode_cal = 4'h6;
            3'h5:    decode_cal = 4'h8;
            default: decode_cal = 4'h0;
        endcase
    endfunction : decode_cal
endpackage : cal_pkg

/* File: verif/cal_link_assertions.sv */
// Purpose: link checks for the select-to-command latency
// Assumes: one clock, synchronous active-low reset
// Notes:   latency is tracked from mode writes seen on the link
`timescale 1ns/1ps
`default_nettype none
module cal_link_assertions (
    // clock and reset
    input wire logic             clk,
    input wire logic             resetn,
    // link
    input wire logic             select_n,
    input wire cal_pkg::cmd_type cmd,
    input wire logic [15:0]      addr
);
    import cal_pkg::*;
    logic [7:0] age_q;
    logic [3:0] lat_q;
    logic       pend_q;
    logic       in_sr_q;
    cmd_type    last_q;
    wire logic  phase = (!select_n && lat_q == 4'h0) || (pend_q && age_q == {4'h0, lat_q});
    wire logic  mr4 = phase && cmd == cmd_mode_write && addr[15:13] == 3'h4;
    wire logic  sel = !select_n;
    //////////
    // own table, so a slip in the shared decode is not mirrored here
    function automatic logic [3:0] lat_of(input logic [2:0] c);
        return (c == 3'h5) ? 4'h8 : (c == 3'h0 || c > 3'h5) ? 4'h0 : {1'b0, c} + 4'h2;
    endfunction : lat_of
    // age saturates so long idle gaps never wrap into a false short gap
    always_ff @(posedge clk)
        age_q <= !resetn ? 8'hff : sel ? 8'h01 : age_q + {7'h00, age_q != 8'hff};
    always_ff @(posedge clk) pend_q <= resetn && (sel ? lat_q != 4'h0 : pend_q && !phase);
    always_ff @(posedge clk) last_q <= !resetn ? cmd_nop : phase ? cmd : last_q;
    always_ff @(posedge clk) lat_q <= !resetn ? 4'h0 : mr4 ? lat_of(addr[8:6]) : lat_q;
    always_ff @(posedge clk)
        in_sr_q <= resetn && (phase ? cmd == cmd_selfrefresh_enter
                                      || (in_sr_q && last_q != cmd_exit) : in_sr_q);
    //////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_select_pulse: assert property (sel |=> !sel)
        else $error("select held low");
    chk_quiet_latency: assert property (pend_q |-> !sel)
        else $error("select inside latency");
    chk_mode_spacing: assert property (sel && last_q == cmd_mode_write
        |-> age_q >= mode_update_cycles + {4'h0, lat_q}) else $error("mode wait short");
    chk_refresh_wait: assert property (sel && last_q == cmd_refresh
        |-> age_q >= refresh_to_powerdown_wait) else $error("refresh wait short");
    chk_sr_entry_hold: assert property (sel && last_q == cmd_selfrefresh_enter
        |-> age_q >= clock_hold_after_selfrefresh_entry) else $error("sr hold short");
    chk_pd_min_time: assert property (sel && last_q == cmd_powerdown_enter
        |-> age_q >= min_powerdown_time) else $error("pd too short");
    chk_sr_exit_wait: assert property (sel && last_q == cmd_exit && in_sr_q
        |-> {8'h00, age_q} >= fast_exit_cycles) else $error("sr exit wait short");
    chk_pd_exit_wait: assert property (sel && last_q == cmd_exit && !in_sr_q
        |-> age_q >= powerdown_exit_wait) else $error("pd exit wait short");
    chk_sr_commands: assert property (phase && in_sr_q && last_q != cmd_exit
        |-> cmd inside {cmd_mode_write, cmd_calibrate, cmd_exit}) else $error("bad sr cmd");
    chk_code_legal: assert property (mr4 |-> addr[8:6] <= 3'h5)
        else $error("reserved latency code");
    cov_latency_set: cover property (mr4 && addr[8:6] != 3'h0);
    cov_sr_entry: cover property (phase && cmd == cmd_selfrefresh_enter);
    cov_sr_exit: cover property (phase && cmd == cmd_exit && in_sr_q);
endmodule : cal_link_assertions
`default_nettype wire

/* File: verif/tb_cs_to_command_latency.sv */
// Purpose: bench driving both ends of the latency link
// Assumes: 50 MHz clock, reset low for 4 cycles
// Notes:   latency per code, gear-down rounding, self refresh refusal
`timescale 1ns/1ps
`default_nettype none
module tb_cs_to_command_latency;
    import cal_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, gear_down = 1'b0, fast_bin = 1'b0;
    logic        req_ready, refused_q, receivers_on, cmd_valid_q, in_lat = 1'b0;
    logic [15:0] req_addr = 16'h0000, addr_q;
    logic [3:0]  select_to_command_cycles, prev;
    logic [3:0]  lat_tab [6] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8};
    logic [11:0] gtab [4] = '{12'h314, 12'h336, 12'h213, 12'h058};
    cmd_type     req_cmd = cmd_nop, cmd_q;
    int          n_errors = 0, checks_done = 0, cyc = 0, sel_t = 0, seen = 0, got = 0;
    int          bad_rcv = 0, bad_off = 0;
    cal_link_if link ();
    cal_controller_end i_cal_controller_end (.clk(clk), .resetn(resetn), .link(link),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .gear_down(gear_down),
        .fast_bin(fast_bin), .req_ready(req_ready), .refused_q(refused_q));
    cal_memory_end i_cal_memory_end (.clk(clk), .resetn(resetn), .link(link),
        .receivers_on(receivers_on), .cmd_valid_q(cmd_valid_q), .cmd_q(cmd_q),
        .addr_q(addr_q), .select_to_command_cycles(select_to_command_cycles));
    cal_link_assertions i_cal_link_assertions (.clk(clk), .resetn(resetn),
        .select_n(link.select_n), .cmd(link.cmd), .addr(link.addr));
    initial forever #10 clk = ~clk;
    //////////
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    // hang guard: whole run needs under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            print_verdict();
        end
    end
    // receivers must be off in the capture cycle, before a new latency takes effect
    always @(negedge clk) begin
        if (cmd_valid_q === 1'b1) begin
            seen = cyc - sel_t;
            got++;
            if (in_lat && receivers_on !== 1'b0)
                bad_off++;
            in_lat = 1'b0;
        end
        if (in_lat && receivers_on !== 1'b1)
            bad_rcv++;
        if (link.select_n === 1'b0) begin
            sel_t = cyc;
            in_lat = (select_to_command_cycles != 4'h0);
        end
    end
    //////////
    task automatic send(input cmd_type c, input logic [15:0] a);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        do @(negedge clk); while (req_ready !== 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
    endtask : send
    task automatic op(input cmd_type c, input logic [15:0] a, input logic [3:0] el);
        int g;
        g = got;
        send(c, a);
        for (int n = 0; n < 40 && got == g; n++) @(posedge clk);
        check(16'(got - g), 16'h0001);
        check(16'(seen), {12'h0, el} + 16'h0001);
        check(16'(cmd_q), 16'(c));
        if (c != cmd_mode_write || !gear_down)
            check(addr_q, a);
        do @(negedge clk); while (req_ready !== 1'b1);
        check(16'(bad_off), 16'h0000);
        check(16'(bad_rcv), 16'h0000);
        @(posedge clk);
    endtask : op
    task automatic refuse(input cmd_type c);
        int g;
        int r;
        g = got;
        r = 0;
        send(c, 16'h0000);
        repeat (20) begin
            @(negedge clk);
            r += int'(refused_q === 1'b1);
        end
        check(16'(r), 16'h0001);
        check(16'(got - g), 16'h0000);
        @(posedge clk);
    endtask : refuse
    //////////
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        prev = 4'h0;
        for (int i = 1; i < 7; i++) begin
            op(cmd_mode_write, {3'h4, 4'h0, 3'(i % 6), 6'h00}, prev);
            check({12'h0, select_to_command_cycles}, {12'h0, lat_tab[i % 6]});
            op(cmd_other, 16'h1230 + 16'(i), lat_tab[i % 6]);
            prev = lat_tab[i % 6];
        end
        $display("test latency codes done");
        foreach (gtab[k]) begin
            gear_down <= gtab[k][9];
            fast_bin <= gtab[k][8];
            @(posedge clk);
            op(cmd_mode_write, {3'h4, 4'h0, gtab[k][6:4], 6'h00}, prev);
            check({12'h0, select_to_command_cycles}, {12'h0, gtab[k][3:0]});
            prev = gtab[k][3:0];
        end
        $display("test gear-down done");
        op(cmd_refresh, 16'h0000, prev);
        op(cmd_powerdown_enter, 16'h0000, prev);
        op(cmd_exit, 16'h0000, prev);
        op(cmd_selfrefresh_enter, 16'h0000, prev);
        refuse(cmd_refresh);
        op(cmd_calibrate, 16'h0000, prev);
        op(cmd_exit, 16'h0000, prev);
        op(cmd_other, 16'h00aa, prev);
        $display("test low power done");
        print_verdict();
    end
endmodule : tb_cs_to_command_latency
`default_nettype wire
